//--- hw/rx_pin_pkg.sv
// Constants for the receiver output and pin control block
// Operation
// [RQ1] Pin powers up as open-drain emphasis flag
// [RQ2] Pin-mode bit turns pin into receive input
// [RQ3] Host sets pin mode only while released
// [RQ4] No host: pin stays emphasis flag output
// [RQ5] Unlock switches serial output to external input
// [RQ6] External input must match output data format
// [RQ7] Device always masters clocks toward converter
// [RQ8] Crystal clocks unlocked, PLL clocks when locked
// [RQ9] Master clock holds PLL 2.7ms, glitch free
// [RQ10] Converter resets itself if changeover upsets it
// [RQ11] Host port is slave; clock never driven
// [RQ12] One input 32k-192k, no rate value output
// [RQ13] Locked master clock follows rate family
// [RQ14] Locked bit clock 64fs, LR clock fs
// [RQ15] Unlocked: 24.576M, 6.144M, 96k from crystal
// [RQ16] Crystal amplifier stops while PLL locked; the code keeps it running while locked if amp_cont is set
// [RQ17] Serial output and input use I2S format
// [RQ18] General flag shows non-PCM status bit 1
// [RQ19] Emphasis flag shows 50/15us consumer emphasis
// [RQ20] Error pin shows PLL lock error
// [RQ21] Reset: error high, CRYSTAL_REFERENCE_IN/4, external data
// [RQ22] Input mode disables pull-down driver permanently
package rx_pin_pkg;
    localparam logic [7:0] ADDR_SYSTEM  = 8'h00;
    localparam logic [7:0] ADDR_CLOCK   = 8'h01;
    localparam logic [7:0] ADDR_DATA    = 8'h02;
    localparam logic [7:0] ADDR_STATUS  = 8'h03;
    localparam int         BIT_PIN_MODE = 6;
    localparam int         BIT_AMP_CONT = 2;
    localparam int         BIT_UNLK_SEL = 5;
    localparam int         BIT_SECOND_RX = 1;
    localparam int         BIT_LOCK_ERR = 4;
    localparam logic [7:0] MASK_SYSTEM  = 8'h44;
    localparam logic [7:0] MASK_CLOCK   = 8'h20;
    localparam logic [7:0] MASK_DATA    = 8'h02;
    localparam logic [7:0] RESET_REG    = 8'h00;
    // Bit clock period in master clock edges is 2**shift
    localparam logic [1:0] SHIFT_XTAL   = 2'h2;
    localparam logic [1:0] SHIFT_XTAL48 = 2'h3;
    localparam logic [1:0] SHIFT_RATE_X1 = 2'h3;
    localparam int         CLK_PERIOD_NS = 25;
    localparam int         HOLDOVER_NS  = 2700000;
    localparam int         HOLDOVER_CYCLES = HOLDOVER_NS / CLK_PERIOD_NS;
    localparam int         HOLD_W       = 17;
    localparam int         DIV_W        = 9;
endpackage

//--- hw/clock_switch.sv
// Glitch-free selector between crystal and PLL master clocks
module clock_switch
    import rx_pin_pkg::*;
(
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic sys_rst_in,
    // Sources
    input  wire logic xtal_clk_in,
    input  wire logic pll_clk_in,
    input  wire logic want_pll_in,
    // Selected clock
    output logic      mck_out,
    output logic      mck_rise_out,
    output logic      on_pll_out
);
    logic sel_q;
    logic mck_q;
    wire  next_src  = want_pll_in ? pll_clk_in : xtal_clk_in;
    // Swap only while both old output and new source are low: no runt pulse
    wire  swap_ok   = (want_pll_in != sel_q) && !mck_q && !next_src;
    wire  sel_d     = swap_ok ? want_pll_in : sel_q;
    wire  mck_d     = sel_d ? pll_clk_in : xtal_clk_in;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            sel_q <= 1'b0;
            mck_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            mck_q <= mck_d;
        end
    end

    assign mck_out      = mck_q;
    assign mck_rise_out = mck_d && !mck_q;
    assign on_pll_out   = sel_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    glitch_free_a: assert property ($changed(sel_q) |-> !$past(mck_q)) // [RQ9]
        else $error("clock source swapped while master clock high");
endmodule

//--- hw/clock_divider.sv
// Bit clock and LR clock divider driven by master clock edges
module clock_divider
    import rx_pin_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Master clock edge and ratio
    input  wire logic       mck_rise_in,
    input  wire logic [1:0] shift_in,
    // Derived clocks
    output logic            bck_out,
    output logic            lrck_out,
    output logic            bck_fall_out
);
    logic [DIV_W-1:0] cnt_q;
    logic             bck_q;
    logic             lrck_q;
    wire  [DIV_W-1:0] cnt_d = mck_rise_in ? cnt_q + 1'b1 : cnt_q;
    // LR clock is 64 bit clocks, so it sits six bits above the bit clock
    wire              bck_d  = cnt_d[shift_in - 2'h1];
    wire              lrck_d = cnt_d[4'(shift_in) + 4'h5];

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cnt_q  <= '0;
            bck_q  <= 1'b0;
            lrck_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            bck_q  <= bck_d;
            lrck_q <= lrck_d;
        end
    end

    assign bck_out      = bck_q;
    assign lrck_out     = lrck_q;
    assign bck_fall_out = bck_q && !bck_d;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    // [RQ14] LR edge only on bit clock fall
    // A ratio change moves both tap points at once, so only steady ratios are judged
    lr_align_a: assert property ($changed(lrck_q) && ($past(shift_in) == $past(shift_in, 2))
        |-> $fell(bck_q)) // [RQ14]
        else $error("LR clock moved off a bit clock falling edge");
endmodule

//--- hw/rx_pin_control.sv
// Output pins, clock sourcing and register port of the audio receiver
module rx_pin_control
    import rx_pin_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLDOVER_CYCLES
)(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    // Receiver core status
    input  wire logic       pll_lock_in,
    input  wire logic       input_present_in,
    input  wire logic [5:0] channel_status_in,
    input  wire logic [1:0] rate_family_in,
    input  wire logic [1:0] rate_multiple_in,
    input  wire logic       demod_data_in,
    // Clock sources
    input  wire logic       crystal_reference_in,
    input  wire logic       pll_clock_in,
    // Receive inputs
    input  wire logic       primary_receive_input_in,
    output logic            receive_data_out,
    // Multipurpose pin
    input  wire logic       multipurpose_pin_in,
    output logic            multipurpose_pin_out,
    output logic            multipurpose_pin_oe_out,
    // Converter side
    input  wire logic       external_serial_audio_in,
    output logic            serial_audio_out,
    output logic            master_clock_out,
    output logic            bit_clock_out,
    output logic            left_right_clock_out,
    // Flags and analog controls
    output logic            error_out,
    output logic            general_flag_out,
    output logic            osc_amp_enable_out,
    output logic      [1:0] pll_family_out
);
    logic [7:0]        system_q;
    logic [7:0]        clock_q;
    logic [7:0]        data_q;
    logic [7:0]        rdata_q;
    logic              locked_q;
    logic [HOLD_W-1:0] hold_q;
    logic              pin_oe_q;
    logic              err_q;
    logic              flag_q;
    logic              amp_q;
    logic              sdo_q;
    logic              rx_q;
    logic [1:0]        family_q;
    logic              mck_rise;
    logic              on_pll;
    logic              bck_fall;

    // Register decode
    wire hit_system = reg_addr_in == ADDR_SYSTEM;
    wire hit_clock  = reg_addr_in == ADDR_CLOCK;
    wire hit_data   = reg_addr_in == ADDR_DATA;
    wire hit_status = reg_addr_in == ADDR_STATUS;
    wire pin_mode   = system_q[BIT_PIN_MODE];
    wire amp_cont   = system_q[BIT_AMP_CONT];
    wire unlock_sel = clock_q[BIT_UNLK_SEL];
    wire second_rx  = data_q[BIT_SECOND_RX];
    // [RQ12] rate code only readable
    wire [7:0] status_w = {3'h0, !locked_q, rate_family_in, rate_multiple_in};
    wire [7:0] rdata_d  = hit_system ? system_q :
                          hit_clock  ? clock_q  :
                          hit_data   ? data_q   :
                          hit_status ? status_w : 8'h00;

    // [RQ11] slave only port
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_read_in ? rdata_d : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    // [RQ4] reset leaves pin an output
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            system_q <= RESET_REG;
            clock_q  <= RESET_REG;
            data_q   <= RESET_REG;
        end else if (reg_write_in) begin
            if (hit_system) system_q <= reg_wdata_in & MASK_SYSTEM;
            if (hit_clock)  clock_q  <= reg_wdata_in & MASK_CLOCK;
            if (hit_data)   data_q   <= reg_wdata_in & MASK_DATA;
        end
    end

    // Channel status decode
    // [RQ19] consumer 50/15us emphasis
    wire emphasis = !channel_status_in[0] && (channel_status_in[5:3] == 3'h1);
    wire non_pcm  = channel_status_in[1];

    // Lock tracking and master clock holdover
    wire lock_lost = locked_q && !pll_lock_in;
    wire [HOLD_W-1:0] hold_d =
        lock_lost          ? HOLD_W'(HOLD_CYCLES) :
        pll_lock_in        ? '0 :
        (hold_q != '0)     ? hold_q - 1'b1 : hold_q;
    // [RQ9] keep free-running PLL during holdover
    wire want_pll = locked_q || (hold_q != '0);

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            locked_q <= 1'b0;
            hold_q   <= '0;
        end else begin
            locked_q <= pll_lock_in;
            hold_q   <= hold_d;
        end
    end

    // [RQ7] clocks come only from this device
    // [RQ8] source follows lock state
    clock_switch u_switch (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .xtal_clk_in  (crystal_reference_in),
        .pll_clk_in   (pll_clock_in),
        .want_pll_in  (want_pll),
        .mck_out      (master_clock_out),
        .mck_rise_out (mck_rise),
        .on_pll_out   (on_pll)
    );

    // [RQ14] locked ratio from rate multiple
    wire [1:0] rate_shift = SHIFT_RATE_X1 - rate_multiple_in;
    // [RQ15] unlocked crystal ratio
    wire [1:0] xtal_shift = unlock_sel ? SHIFT_XTAL48 : SHIFT_XTAL;
    wire [1:0] div_shift  = on_pll ? rate_shift : xtal_shift;

    clock_divider u_divider (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .mck_rise_in  (mck_rise),
        .shift_in     (div_shift),
        .bck_out      (bit_clock_out),
        .lrck_out     (left_right_clock_out),
        .bck_fall_out (bck_fall)
    );

    // [RQ5] unlock selects external data unchanged
    wire sdo_src = locked_q && pll_lock_in ? demod_data_in : external_serial_audio_in;
    // [RQ2] pin feeds the receiver when selected
    wire rx_d    = (pin_mode && second_rx) ? multipurpose_pin_in : primary_receive_input_in;
    // [RQ1] pull low only with emphasis present
    // [RQ22] input mode never enables pull-down
    wire pin_oe_d = !pin_mode && input_present_in && emphasis;

    always_ff @(posedge clock_in) begin
        // [RQ21] reset values
        if (sys_rst_in) begin
            pin_oe_q <= 1'b0;
            err_q    <= 1'b1;
            flag_q   <= 1'b0;
            amp_q    <= 1'b1;
            sdo_q    <= 1'b0;
            rx_q     <= 1'b0;
            family_q <= 2'h0;
        end else begin
            pin_oe_q <= pin_oe_d;
            // [RQ20] error high when unlocked
            err_q    <= !pll_lock_in;
            // [RQ18] non-PCM flag
            flag_q   <= non_pcm;
            // [RQ16] amplifier off while locked, unless amp_cont is set
            amp_q    <= !pll_lock_in || amp_cont;
            // [RQ17] bit passes as-is, I2S framing kept by source
            sdo_q    <= sdo_src;
            rx_q     <= rx_d;
            // [RQ13] PLL runs at the family master rate
            family_q <= rate_family_in;
        end
    end

    assign multipurpose_pin_out    = 1'b0;
    assign multipurpose_pin_oe_out = pin_oe_q;
    assign error_out               = err_q;
    assign general_flag_out        = flag_q;
    assign osc_amp_enable_out      = amp_q;
    assign serial_audio_out        = sdo_q;
    assign receive_data_out        = rx_q;
    assign pll_family_out          = family_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence hold_start_s;
        $fell(locked_q) ##1 1'b1;
    endsequence
    sequence hold_done_s;
        !locked_q && (hold_q == '0);
    endsequence

    emph_drive_a: assert property (pin_oe_d |=> multipurpose_pin_oe_out) // [RQ1]
        else $error("emphasis did not pull the pin low");
    pin_input_a: assert property (pin_mode |=> !multipurpose_pin_oe_out) // [RQ22]
        else $error("pin driven while in input mode");
    pin_route_a: assert property (pin_mode && second_rx |=>
        receive_data_out == $past(multipurpose_pin_in)) // [RQ2]
        else $error("pin data not routed to receiver");
    data_fallback_a: assert property (!pll_lock_in |=>
        serial_audio_out == $past(external_serial_audio_in)) // [RQ5]
        else $error("serial output not taken from external input");
    hold_pll_a: assert property (hold_start_s |-> want_pll [*4]) // [RQ9]
        else $error("PLL clock dropped early after unlock");
    hold_end_a: assert property (hold_done_s |-> ##[0:16] !on_pll) // [RQ9]
        else $error("crystal source not chosen after holdover");
    lock_error_a: assert property (pll_lock_in |=> !error_out ##1 1'b1) // [RQ20]
        else $error("error flag set while locked");
    amp_stop_a: assert property (pll_lock_in && !amp_cont |=> !osc_amp_enable_out) // [RQ16]
        else $error("amplifier running while locked");
    nonpcm_flag_a: assert property (non_pcm |=> general_flag_out) // [RQ18]
        else $error("non-PCM flag not shown");
    reset_state_a: assert property (@(posedge clock_in) disable iff (1'b0) sys_rst_in |=>
        error_out && !multipurpose_pin_oe_out && osc_amp_enable_out) // [RQ21]
        else $error("outputs wrong after reset");
endmodule

//--- testbench/converter_model.sv
// Audio converter model slaved to the receiver clocks, with clock measurement
module converter_model (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Clocks from the receiver
    input  wire logic       master_clock_in,
    input  wire logic       bit_clock_in,
    input  wire logic       left_right_clock_in,
    // Data and measurements
    output logic            sdata_out,
    output logic      [7:0] mck_period_out,
    output logic      [7:0] bck_div_out,
    output logic      [7:0] lr_div_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0]  prev_q;
    logic [7:0]  cyc_q;
    logic [7:0]  mck_q;
    logic [7:0]  bck_q;
    logic [15:0] word_q;
    wire  logic  mck_rise = master_clock_in & ~prev_q[0];
    wire  logic  bck_rise = bit_clock_in & ~prev_q[1];
    wire  logic  bck_fall = ~bit_clock_in & prev_q[1];
    wire  logic  lr_rise  = left_right_clock_in & ~prev_q[2];
    // Slave only, drives no clock back
    // Data in the receiver's own format
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            prev_q         <= 3'h0;
            cyc_q          <= 8'h00;
            mck_q          <= 8'h00;
            bck_q          <= 8'h00;
            word_q         <= 16'hc5a3;
            sdata_out      <= 1'b0;
            mck_period_out <= 8'h00;
            bck_div_out    <= 8'h00;
            lr_div_out     <= 8'h00;
        end else begin
            prev_q <= {left_right_clock_in, bit_clock_in, master_clock_in};
            cyc_q  <= mck_rise ? 8'h01 : cyc_q + 8'h01;
            mck_q  <= bck_rise ? {7'h0, mck_rise} : mck_q + {7'h0, mck_rise};
            bck_q  <= lr_rise ? {7'h0, bck_rise} : bck_q + {7'h0, bck_rise};
            if (mck_rise) mck_period_out <= cyc_q;
            if (bck_rise) bck_div_out <= mck_q;
            if (lr_rise) lr_div_out <= bck_q;
            // Data changes on the falling bit clock so it is stable at the rise
            if (bck_fall) begin
                sdata_out <= word_q[15];
                word_q    <= {word_q[14:0], word_q[15]};
            end
        end
    end
endmodule

//--- testbench/rx_pin_control_bench.sv
// Self-checking bench for the receiver pin, data and clock control
module rx_pin_control_bench
    import rx_pin_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock_in, sys_rst_in, reg_write_in, reg_read_in, pin_drive;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, mck_p, bck_d, lr_d;
    logic       pll_lock_in, input_present_in, demod_data_in, ext_data, pin_level;
    logic [5:0] channel_status_in;
    logic [1:0] rate_family_in, rate_multiple_in, pll_family_out;
    logic       crystal_reference_in, pll_clock_in, primary_receive_input_in;
    logic       receive_data_out, pin_o, pin_oe, serial_audio_out, mck, bck, lrck;
    logic       error_out, general_flag_out, osc_amp_enable_out;
    logic [3:0] src_q;
    int         miscompares, n_checks;
    // Open-drain pin with pull-up: low while driven, else the outside source
    assign pin_level = pin_oe ? pin_o : pin_drive;

    rx_pin_control #(.HOLD_CYCLES(80)) uut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .pll_lock_in(pll_lock_in), .input_present_in(input_present_in),
        .channel_status_in(channel_status_in), .rate_family_in(rate_family_in),
        .rate_multiple_in(rate_multiple_in), .demod_data_in(demod_data_in),
        .crystal_reference_in(crystal_reference_in), .pll_clock_in(pll_clock_in),
        .primary_receive_input_in(primary_receive_input_in),
        .receive_data_out(receive_data_out), .multipurpose_pin_in(pin_level),
        .multipurpose_pin_out(pin_o), .multipurpose_pin_oe_out(pin_oe),
        .external_serial_audio_in(ext_data), .serial_audio_out(serial_audio_out),
        .master_clock_out(mck), .bit_clock_out(bck), .left_right_clock_out(lrck),
        .error_out(error_out), .general_flag_out(general_flag_out),
        .osc_amp_enable_out(osc_amp_enable_out), .pll_family_out(pll_family_out));
    converter_model conv (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .master_clock_in(mck),
        .bit_clock_in(bck), .left_right_clock_in(lrck), .sdata_out(ext_data),
        .mck_period_out(mck_p), .bck_div_out(bck_d), .lr_div_out(lr_d));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // Crystal period 4 cycles, PLL period 6, so the source shows in the period
    always @(posedge clock_in) begin
        src_q                <= (src_q == 4'hb) ? 4'h0 : src_q + 4'h1;
        crystal_reference_in <= src_q[1];
        pll_clock_in         <= (src_q >= 4'h3 && src_q < 4'h6) || src_q >= 4'h9;
        demod_data_in        <= src_q[0] ^ src_q[2];
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        reg_addr_in  <= addr;
        reg_wdata_in <= data;
        reg_write_in <= 1'b1;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge clock_in);
        reg_addr_in <= addr;
        reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1;
        check(what, exp, reg_rdata_out);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task automatic check_data(input logic from_demod, input string what);
        logic ext_p, dem_p;
        @(negedge clock_in);
        ext_p = ext_data;
        dem_p = demod_data_in;
        repeat (40) begin
            @(negedge clock_in);
            check(what, from_demod ? dem_p : ext_p, serial_audio_out);
            ext_p = ext_data;
            dem_p = demod_data_in;
        end
    endtask
    task automatic check_clocks(input logic [7:0] m, input logic [7:0] b, input string what);
        // Two full LR periods at the slowest ratio must pass after a change
        settle(8000);
        check({what, " mck"}, m, mck_p);
        check({what, " bck"}, b, bck_d);
        check({what, " lr"}, 8'h40, lr_d);
    endtask

    task automatic t_reset;
        settle(1);
        check("error", 1'b1, error_out);
        check("pin oe", 1'b0, pin_oe);
        reg_rd(ADDR_SYSTEM, 8'h00, "system");
        reg_rd(ADDR_CLOCK, 8'h00, "clock");
        reg_rd(ADDR_DATA, 8'h00, "data");
        reg_rd(ADDR_STATUS, 8'h10, "status");
        check_data(1'b0, "serial reset");
        check_clocks(8'h04, 8'h04, "xtal");
    endtask
    task automatic t_flags;
        @(posedge clock_in);
        channel_status_in <= 6'h08;
        settle(2);
        check("oe absent", 1'b0, pin_oe);
        input_present_in <= 1'b1;
        settle(2);
        check("oe emphasis", 1'b1, pin_oe);
        channel_status_in <= 6'h0b;
        settle(2);
        check("oe professional", 1'b0, pin_oe);
        check("general", 1'b1, general_flag_out);
        channel_status_in <= 6'h00;
        input_present_in  <= 1'b0;
        settle(2);
        check("general off", 1'b0, general_flag_out);
    endtask
    task automatic t_lock;
        @(posedge clock_in);
        rate_family_in   <= 2'h1;
        rate_multiple_in <= 2'h1;
        pll_lock_in      <= 1'b1;
        settle(2);
        check("error lock", 1'b0, error_out);
        check("amp lock", 1'b0, osc_amp_enable_out);
        check("family", 8'h01, pll_family_out);
        reg_rd(ADDR_STATUS, 8'h05, "status lock");
        check_data(1'b1, "serial lock");
        check_clocks(8'h06, 8'h04, "pll x2");
        rate_multiple_in <= 2'h0;
        check_clocks(8'h06, 8'h08, "pll x1");
        reg_wr(ADDR_SYSTEM, 8'h04);
        settle(2);
        check("amp continuous", 1'b1, osc_amp_enable_out);
        pll_lock_in <= 1'b0;
        settle(2);
        check("error unlock", 1'b1, error_out);
        check_data(1'b0, "serial unlock");
        check("mck holdover", 8'h06, mck_p);
        check_clocks(8'h04, 8'h04, "xtal again");
        reg_wr(ADDR_SYSTEM, 8'h00);
    endtask
    task automatic t_unlock_sel;
        reg_wr(ADDR_CLOCK, 8'h20);
        reg_rd(ADDR_CLOCK, 8'h20, "clock select");
        check_clocks(8'h04, 8'h08, "xtal select");
        reg_wr(ADDR_CLOCK, 8'h00);
    endtask
    task automatic t_pin_mode;
        @(posedge clock_in);
        primary_receive_input_in <= 1'b1;
        settle(2);
        check("rx primary", 1'b1, receive_data_out);
        // Mode set while the pin is released
        reg_wr(ADDR_SYSTEM, 8'h40);
        reg_wr(8'h07, 8'hff);
        reg_rd(8'h07, 8'h00, "unmapped");
        reg_rd(ADDR_SYSTEM, 8'h40, "system mode");
        input_present_in  <= 1'b1;
        channel_status_in <= 6'h08;
        settle(8);
        check("oe input mode", 1'b0, pin_oe);
        reg_wr(ADDR_DATA, 8'h02);
        settle(2);
        check("rx pin low", 1'b0, receive_data_out);
        pin_drive                <= 1'b1;
        primary_receive_input_in <= 1'b0;
        settle(2);
        check("rx pin high", 1'b1, receive_data_out);
    endtask

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        {sys_rst_in, reg_write_in, reg_read_in, pin_drive} = 4'h8;
        {reg_addr_in, reg_wdata_in, src_q} = 20'h0;
        {pll_lock_in, input_present_in, demod_data_in, primary_receive_input_in} = 4'h0;
        {channel_status_in, rate_family_in, rate_multiple_in} = 10'h0;
        {crystal_reference_in, pll_clock_in, miscompares, n_checks} = '0;
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_flags();
        t_lock();
        t_unlock_sel();
        t_pin_mode();
        wrap_up();
    end
    // Tests need about 40200 cycles; a hang ends the run as a failure
    initial begin
        repeat (60000) @(posedge clock_in);
        miscompares++;
        wrap_up();
    end
endmodule
